// ==== logic/pwm_group_pkg.sv ====
// constants, register map and state type of the pwm and capture group
package pwm_group_pkg;
    localparam int CNT_W = 16;
    localparam int PRE_W = 8;
    localparam int DIV_W = 4;
    localparam int NCH = 4;
    localparam int NPAIR = 2;
    localparam int ADDR_W = 8;
    // register offsets
    localparam logic [7:0] OFS_PPR = 8'h00;
    localparam logic [7:0] OFS_CSR = 8'h04;
    localparam logic [7:0] OFS_PCR = 8'h08;
    localparam logic [7:0] OFS_CNR = 8'h0C;
    localparam logic [7:0] OFS_CMR = 8'h10;
    localparam logic [7:0] OFS_PDR = 8'h14;
    localparam logic [7:0] OFS_CH_STEP = 8'h0C;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE_REGISTER = 8'h40;
    localparam logic [7:0] OFS_PIIR = 8'h44;
    localparam logic [7:0] OFS_CCR = 8'h50;
    localparam logic [7:0] OFS_CCR_STEP = 8'h04;
    localparam logic [7:0] OFS_CRL = 8'h58;
    localparam logic [7:0] OFS_CFL = 8'h5C;
    localparam logic [7:0] OFS_LATCH_STEP = 8'h08;
    localparam logic [7:0] OFS_CAPEN = 8'h78;
    localparam logic [7:0] OFS_POE = 8'h7C;
    // prescale register fields
    localparam int PPR_PRE_POS = 0;
    localparam int PPR_DZ_POS = 16;
    localparam int PPR_STEP = 8;
    // divider select field and codes
    localparam int CSR_STEP = 4;
    localparam logic [31:0] CSR_MASK = 32'h0000_7777;
    localparam logic [2:0] DIV_BY1 = 3'h4;
    localparam logic [2:0] DIV_BY2 = 3'h0;
    localparam logic [2:0] DIV_BY4 = 3'h1;
    localparam logic [2:0] DIV_BY8 = 3'h2;
    localparam logic [2:0] DIV_BY16 = 3'h3;
    // channel control fields
    localparam int PCR_STEP = 8;
    localparam int PCR_EN = 0;
    localparam int PCR_INV = 2;
    localparam int PCR_MOD = 3;
    localparam int PCR_DZ = 4;
    localparam logic [31:0] PCR_MASK = 32'h0D0D_0D3D;
    // capture control fields
    localparam int CC_STEP = 16;
    localparam int CC_INV = 0;
    localparam int CC_RIE = 1;
    localparam int CC_FIE = 2;
    localparam int CC_EN = 3;
    localparam int CC_FLAG = 4;
    localparam logic [31:0] CCR_MASK = 32'h001F_001F;
    localparam logic [31:0] CCR_FLAG_MASK = 32'h0010_0010;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [31:0] group_prescale_and_deadgap;
        logic [31:0] clock_divider_select;
        logic [31:0] channel_control_register;
        logic [NPAIR-1:0][31:0] ccr;
        logic [NCH-1:0][CNT_W-1:0] period_reload;
        logic [NCH-1:0][CNT_W-1:0] duty_compare;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        logic [NCH-1:0][CNT_W-1:0] cmp;
        logic [NCH-1:0][CNT_W-1:0] crl;
        logic [NCH-1:0][CNT_W-1:0] cfl;
        logic [NCH-1:0][DIV_W-1:0] div;
        logic [NPAIR-1:0][PRE_W-1:0] pre_cnt;
        logic [NPAIR-1:0][PRE_W-1:0] dz_cnt;
        logic [NPAIR-1:0] dz_prev;
        logic [NCH-1:0] interrupt_enable_register;
        logic [NCH-1:0] piir;
        logic [NCH-1:0] capen;
        logic [NCH-1:0] pin_output_enable;
        logic [NCH-1:0] run;
        logic [NCH-1:0] started;
        logic [NCH-1:0] cap_prev;
        logic [NCH-1:0] pout;
        logic irq;
        logic [31:0] rdata;
    } state_t;
endpackage

// ==== logic/pwm_capture_timer_group.sv ====
// one pwm group: two generators, four channels, capture and apb registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

//Behaviour
// - each generator: 8-bit prescaler, two dividers, two timers, dead zone, two outputs
// - period counter and duty comparator are 16 bits wide
// - rate = clock/(prescale+1)/divider/(reload+1); duty (compare+1)/(reload+1)
// - compare at or above reload keeps the output high all period
// - otherwise low reload-compare units, high compare+1 units
// - compare zero gives reload low units and one high unit
// - reload writes are buffered and apply from the next period
// - live down counter is readable through counter_readback
// - reload mode one reloads the counter at zero and keeps counting
// - reload value zero halts the counter when it reaches zero
// - reload mode zero stops the counter after a single period
// - duty compare writes are taken any time, used from next period
// - dead zone delays rising edges of a pair by dead_gap_length
// - capture: rising edge latches counter to rise, falling to fall
// - capture flags gated by rise and fall enable bits 1,2 and 17,18
// - raising a capture flag reloads that channel counter at once
// - capture channel n uses the down counter of pwm channel n
// - pwm and capture of a channel share one line, merged per group
// - each capture channel has rise latch, fall latch, capture flag
// - period flag is set when a channel counter reaches zero
// - complement enable drives both pair outputs from the even timer
// - divider codes: 100 /1, 011 /16, 010 /8, 001 /4, 000 /2
// - prescale zero stops the prescaler and both timers it feeds
module pwm_capture_timer_group
    import pwm_group_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // channel pins
    output logic [NCH-1:0] pwm_out,
    output logic [NCH-1:0] pwm_oe_n,
    input wire logic [NCH-1:0] cap_in,
    // merged group interrupt
    output logic group_irq
);

    state_t s_r;
    state_t s_nxt;
    logic [NPAIR-1:0] pre_tick;
    logic [NCH-1:0] ch_tick;
    logic [NCH-1:0] wave;
    logic [31:0] rd_val;
    logic hit;

    // divider select to terminal count (divisor minus one)
    // divider code decode
    function automatic logic [DIV_W-1:0] div_last(input logic [2:0] sel);
        case (sel)
            DIV_BY1: div_last = 4'h0;
            DIV_BY2: div_last = 4'h1;
            DIV_BY4: div_last = 4'h3;
            DIV_BY8: div_last = 4'h7;
            DIV_BY16: div_last = 4'hF;
            default: div_last = 4'h1;
        endcase
    endfunction

    function automatic logic [7:0] addr_of(input logic [7:0] base,
                                           input int idx,
                                           input logic [7:0] step);
        addr_of = base + 8'(idx) * step;
    endfunction

    always_comb begin
        logic wr;
        logic en;
        logic cin;
        logic src;
        logic dzen;
        int g;
        int b;
        wr = psel && penable && pwrite;
        en = 1'b0;
        cin = 1'b0;
        src = 1'b0;
        dzen = 1'b0;
        g = 0;
        b = 0;
        s_nxt = s_r;
        rd_val = RESET_WORD;
        hit = 1'b0;
        pre_tick = '0;
        ch_tick = '0;
        wave = '0;

        for (int p = 0; p < NPAIR; p++) begin
            if (s_r.group_prescale_and_deadgap[PPR_PRE_POS + p*PPR_STEP +: PRE_W] == 8'h00) begin
                s_nxt.pre_cnt[p] = 8'h00;
            end else if (s_r.pre_cnt[p] >=
                         s_r.group_prescale_and_deadgap[PPR_PRE_POS + p*PPR_STEP +: PRE_W]) begin
                s_nxt.pre_cnt[p] = 8'h00;
                pre_tick[p] = 1'b1;
            end else begin
                s_nxt.pre_cnt[p] = PRE_W'(s_r.pre_cnt[p] + 8'h01);
            end
        end

        for (int c = 0; c < NCH; c++) begin
            if (!s_r.channel_control_register[c*PCR_STEP + PCR_EN]) begin
                s_nxt.div[c] = 4'h0;
            end else if (pre_tick[c/2]) begin
                if (s_r.div[c] >= div_last(s_r.clock_divider_select[c*CSR_STEP +: 3])) begin
                    s_nxt.div[c] = 4'h0;
                    ch_tick[c] = 1'b1;
                end else begin
                    s_nxt.div[c] = DIV_W'(s_r.div[c] + 4'h1);
                end
            end
        end

        // register decode, read and write
        case (paddr)
            OFS_PPR: begin
                hit = 1'b1;
                rd_val = s_r.group_prescale_and_deadgap;
                if (wr) s_nxt.group_prescale_and_deadgap = pwdata;
            end
            OFS_CSR: begin
                hit = 1'b1;
                rd_val = s_r.clock_divider_select;
                if (wr) s_nxt.clock_divider_select = pwdata & CSR_MASK;
            end
            OFS_PCR: begin
                hit = 1'b1;
                rd_val = s_r.channel_control_register;
                if (wr) s_nxt.channel_control_register = pwdata & PCR_MASK;
            end
            OFS_INTERRUPT_ENABLE_REGISTER: begin
                hit = 1'b1;
                rd_val = {28'h0000000, s_r.interrupt_enable_register};
                if (wr) s_nxt.interrupt_enable_register = pwdata[NCH-1:0];
            end
            OFS_PIIR: begin
                hit = 1'b1;
                rd_val = {28'h0000000, s_r.piir};
                if (wr) s_nxt.piir = s_r.piir & ~pwdata[NCH-1:0];
            end
            OFS_CAPEN: begin
                hit = 1'b1;
                rd_val = {28'h0000000, s_r.capen};
                if (wr) s_nxt.capen = pwdata[NCH-1:0];
            end
            OFS_POE: begin
                hit = 1'b1;
                rd_val = {28'h0000000, s_r.pin_output_enable};
                if (wr) s_nxt.pin_output_enable = pwdata[NCH-1:0];
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        for (int p = 0; p < NPAIR; p++) begin
            if (paddr == addr_of(OFS_CCR, p, OFS_CCR_STEP)) begin
                hit = 1'b1;
                rd_val = s_r.ccr[p];
                if (wr) begin
                    s_nxt.ccr[p] = (pwdata & CCR_MASK & ~CCR_FLAG_MASK) |
                                   (s_r.ccr[p] & CCR_FLAG_MASK & ~pwdata);
                end
            end
        end
        for (int c = 0; c < NCH; c++) begin
            if (paddr == addr_of(OFS_CNR, c, OFS_CH_STEP)) begin
                hit = 1'b1;
                rd_val = {16'h0000, s_r.period_reload[c]};
                if (wr) s_nxt.period_reload[c] = pwdata[CNT_W-1:0];
            end
            // compare buffer accepts writes at any time
            if (paddr == addr_of(OFS_CMR, c, OFS_CH_STEP)) begin
                hit = 1'b1;
                rd_val = {16'h0000, s_r.duty_compare[c]};
                if (wr) s_nxt.duty_compare[c] = pwdata[CNT_W-1:0];
            end
            if (paddr == addr_of(OFS_PDR, c, OFS_CH_STEP)) begin
                hit = 1'b1;
                rd_val = {16'h0000, s_r.cnt[c]};
            end
            if (paddr == addr_of(OFS_CRL, c, OFS_LATCH_STEP)) begin
                hit = 1'b1;
                rd_val = {16'h0000, s_r.crl[c]};
            end
            if (paddr == addr_of(OFS_CFL, c, OFS_LATCH_STEP)) begin
                hit = 1'b1;
                rd_val = {16'h0000, s_r.cfl[c]};
            end
        end
        if (psel && !penable) s_nxt.rdata = rd_val;

        // channel timers, after the bus so hardware sets win over clears
        for (int c = 0; c < NCH; c++) begin
            en = s_r.channel_control_register[c*PCR_STEP + PCR_EN];
            g = c / 2;
            b = (c % 2) * CC_STEP;
            if (!en) begin
                s_nxt.run[c] = 1'b0;
                s_nxt.started[c] = 1'b0;
            end else if (!s_r.started[c]) begin
                s_nxt.started[c] = 1'b1;
                s_nxt.run[c] = 1'b1;
                s_nxt.cnt[c] = s_r.period_reload[c];
                s_nxt.cmp[c] = s_r.duty_compare[c];
            end else if (s_r.run[c] && ch_tick[c]) begin
                if (s_r.cnt[c] == 16'h0000) begin
                    s_nxt.piir[c] = 1'b1;
                    // auto reload, new period from buffers
                    if (s_r.channel_control_register[c*PCR_STEP + PCR_MOD] &&
                        s_r.period_reload[c] != 16'h0000) begin
                        s_nxt.cnt[c] = s_r.period_reload[c];
                        s_nxt.cmp[c] = s_r.duty_compare[c];
                    end else begin
                        // halt on zero or one shot
                        s_nxt.run[c] = 1'b0;
                    end
                end else begin
                    s_nxt.cnt[c] = CNT_W'(s_r.cnt[c] - 16'h0001);
                end
            end

            cin = cap_in[c] ^ s_r.ccr[g][b + CC_INV];
            s_nxt.cap_prev[c] = cin;
            if (s_r.ccr[g][b + CC_EN] && s_r.capen[c] && s_r.started[c]) begin
                if (cin && !s_r.cap_prev[c]) begin
                    s_nxt.crl[c] = s_r.cnt[c];
                    if (s_r.ccr[g][b + CC_RIE]) begin
                        s_nxt.ccr[g][b + CC_FLAG] = 1'b1;
                        s_nxt.cnt[c] = s_r.period_reload[c];
                    end
                end
                if (!cin && s_r.cap_prev[c]) begin
                    s_nxt.cfl[c] = s_r.cnt[c];
                    if (s_r.ccr[g][b + CC_FIE]) begin
                        s_nxt.ccr[g][b + CC_FLAG] = 1'b1;
                        s_nxt.cnt[c] = s_r.period_reload[c];
                    end
                end
            end

            // high while counter at or below compare
            wave[c] = en && ((s_r.run[c] && s_r.cnt[c] <= s_r.cmp[c]) ^
                             s_r.channel_control_register[c*PCR_STEP + PCR_INV]);
            s_nxt.pout[c] = wave[c];
        end

        // dead zone per pair, delays rising edges
        for (int p = 0; p < NPAIR; p++) begin
            dzen = s_r.channel_control_register[PCR_DZ + p];
            src = wave[2*p];
            s_nxt.dz_prev[p] = src;
            if (src != s_r.dz_prev[p]) begin
                s_nxt.dz_cnt[p] = s_r.group_prescale_and_deadgap[PPR_DZ_POS + p*PPR_STEP +: PRE_W];
            end else if (s_r.dz_cnt[p] != 8'h00 && ch_tick[2*p]) begin
                s_nxt.dz_cnt[p] = PRE_W'(s_r.dz_cnt[p] - 8'h01);
            end
            // even timer drives both outputs when paired
            if (dzen) begin
                s_nxt.pout[2*p] = src && s_nxt.dz_cnt[p] == 8'h00;
                s_nxt.pout[2*p+1] = !src && s_nxt.dz_cnt[p] == 8'h00 &&
                                    s_r.channel_control_register[2*p*PCR_STEP + PCR_EN];
            end
        end

        // channel lines merged into the group line
        s_nxt.irq = |(s_nxt.piir & s_nxt.interrupt_enable_register) |
                    |(s_nxt.ccr[0] & CCR_FLAG_MASK) |
                    |(s_nxt.ccr[1] & CCR_FLAG_MASK);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign pwm_out = s_r.pout;
    // pin driven only where software enabled the output
    assign pwm_oe_n = ~s_r.pin_output_enable;
    assign group_irq = s_r.irq;

    // checks on channel 0
    logic wrap0;
    logic rise0;
    assign wrap0 = s_r.run[0] && ch_tick[0] && s_r.cnt[0] == 16'h0000;
    assign rise0 = s_r.ccr[0][CC_EN] && s_r.capen[0] && s_r.started[0] &&
                   (cap_in[0] ^ s_r.ccr[0][CC_INV]) && !s_r.cap_prev[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_prescale_stop: assert property (
        s_r.group_prescale_and_deadgap[PRE_W-1:0] == 8'h00 |-> !pre_tick[0] && !ch_tick[0])
        else $error("timer ticked with prescale zero");
    a_auto_reload: assert property (
        wrap0 && s_r.channel_control_register[PCR_MOD] && s_r.period_reload[0] != 16'h0000 &&
        !rise0 |=> s_r.cnt[0] == $past(s_r.period_reload[0]) && s_r.run[0])
        else $error("counter did not reload at zero");
    a_zero_halt: assert property (
        wrap0 && s_r.period_reload[0] == 16'h0000 |=> !s_r.run[0])
        else $error("counter kept running with reload zero");
    a_one_shot: assert property (
        wrap0 && !s_r.channel_control_register[PCR_MOD] && s_r.channel_control_register[PCR_EN] |=> !s_r.run[0])
        else $error("one shot counter did not stop");
    a_period_flag: assert property (
        wrap0 |=> s_r.piir[0])
        else $error("period flag missing at zero");
    a_duty_hold: assert property (
        s_r.started[0] && s_r.channel_control_register[PCR_EN] && !wrap0 |=> $stable(s_r.cmp[0]))
        else $error("compare changed inside a period");
    a_full_high: assert property (
        s_r.channel_control_register[PCR_EN] && !s_r.channel_control_register[PCR_INV] && !s_r.channel_control_register[PCR_DZ] &&
        s_r.run[0] && s_r.cnt[0] <= s_r.cmp[0] |=> pwm_out[0])
        else $error("output low while counter under compare");
    a_rise_latch: assert property (
        rise0 |=> s_r.crl[0] == $past(s_r.cnt[0]))
        else $error("rising edge not latched");
    a_cap_reload: assert property (
        rise0 && s_r.ccr[0][CC_RIE] |=> s_r.ccr[0][CC_FLAG] &&
        s_r.cnt[0] == $past(s_r.period_reload[0]))
        else $error("capture flag without counter reload");
    a_irq_merge: assert property (
        s_r.piir[0] && s_r.interrupt_enable_register[0] |-> group_irq)
        else $error("enabled period flag not on group line");

endmodule
`default_nettype wire

// ==== sim/pin_partner.sv ====
// pin-side model: pulse source on capture inputs, load on pwm pin 0
`timescale 1ns/10ps
`default_nettype none
module pin_partner
    import pwm_group_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // device pins
    input wire logic [NCH-1:0] pwm_out,
    input wire logic [NCH-1:0] pwm_oe_n,
    output logic [NCH-1:0] cap_in,
    // bench control and measurements
    input wire logic [NCH-1:0] toggle_req,
    output logic [15:0] high_len,
    output logic [15:0] low_len
);
    logic [15:0] run_len;
    logic prev_lvl;
    // each request flips one source line, which then holds its level
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_in <= 4'h0;
        end else begin
            cap_in <= cap_in ^ toggle_req;
        end
    end
    // run lengths of pin 0, only while the device drives it
    always_ff @(posedge clk) begin
        if (rst || pwm_oe_n[0]) begin
            run_len <= 16'h0001;
            prev_lvl <= 1'b0;
            high_len <= 16'h0000;
            low_len <= 16'h0000;
        end else if (pwm_out[0] == prev_lvl) begin
            run_len <= run_len + 16'h0001;
        end else begin
            if (prev_lvl) begin
                high_len <= run_len;
            end else begin
                low_len <= run_len;
            end
            run_len <= 16'h0001;
            prev_lvl <= pwm_out[0];
        end
    end
endmodule
`default_nettype wire

// ==== sim/pwm_capture_timer_group_bench.sv ====
// self-checking bench of the pwm and capture group
`timescale 1ns/10ps
`default_nettype none
module pwm_capture_timer_group_bench
    import pwm_group_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, group_irq, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pwm_out, pwm_oe_n, cap_in, toggle_req;
    logic [15:0] high_len, low_len;
    int errors, checks_done;
    pwm_capture_timer_group dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n), .cap_in(cap_in),
        .group_irq(group_irq));
    pin_partner partner_u (.clk(clk), .rst(rst), .pwm_out(pwm_out),
        .pwm_oe_n(pwm_oe_n), .cap_in(cap_in), .toggle_req(toggle_req),
        .high_len(high_len), .low_len(low_len));
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // apb transfer: setup, access until pready, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input int ch);
        toggle_req[ch] <= 1'b1;
        @(posedge clk);
        toggle_req[ch] <= 1'b0;
    endtask
    task automatic lens(input int hi, input int lo, input string what);
        chk({16'h0000, high_len}, hi, what);
        chk({16'h0000, low_len}, lo, what);
    endtask
    task automatic t_reset();
        chk({28'h0, pwm_oe_n}, 32'h0000_000F, "oe after reset");
        apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h0, "prescale reset");
        apb(1'b1, 8'h14, 32'h1234);
        apb(1'b0, 8'h14, 32'h0); chk(rd, 32'h0, "readback ro");
        apb(1'b0, 8'h48, 32'h0); chk({31'h0, er}, 32'h1, "unmapped");
    endtask
    task automatic t_pwm();
        int lows;
        logic [2:0] code [5] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3};
        int dv [5] = '{1, 2, 4, 8, 16};
        // start order: divider, prescale, control, duty, reload, irq and capture enables, pins, run
        apb(1'b1, 8'h04, 32'h4);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h08, 32'h8);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h0C, 32'h4);
        apb(1'b1, 8'h40, 32'h0);
        apb(1'b1, 8'h78, 32'h0);
        apb(1'b1, 8'h7C, 32'h1);
        chk({28'h0, pwm_oe_n}, 32'h0000_000E, "oe set");
        apb(1'b1, 8'h08, 32'h9);
        tick(60); lens(4, 6, "duty 1 of 4");
        apb(1'b1, 8'h10, 32'h2);
        tick(60); lens(6, 4, "duty 2 of 4");
        apb(1'b1, 8'h10, 32'h0);
        tick(60); lens(2, 8, "duty 0");
        apb(1'b1, 8'h0C, 32'h6);
        tick(80); lens(2, 12, "new reload");
        apb(1'b1, 8'h10, 32'h6);
        tick(60);
        lows = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (pwm_out[0] !== 1'b1) lows++;
        end
        chk(lows, 0, "always high");
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h0C, 32'h1);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h04, {29'h0, code[i]});
            tick(300); lens(2 * dv[i], 2 * dv[i], "divider");
        end
        // stop: reload zero, wait for the counter, then clear run
        apb(1'b1, 8'h0C, 32'h0);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, 8'h14, 32'h0);
            if (rd === 32'h0) break;
        end
        chk(rd, 32'h0, "halted at zero");
        apb(1'b1, 8'h08, 32'h0);
    endtask
    task automatic t_oneshot();
        apb(1'b1, 8'h04, 32'h4);
        apb(1'b1, 8'h40, 32'h1);
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b1, 8'h08, 32'h1);
        tick(40);
        apb(1'b0, 8'h14, 32'h0); chk(rd, 32'h0, "one shot stopped");
        apb(1'b0, 8'h44, 32'h0); chk(rd, 32'h1, "period flag");
        chk({31'h0, group_irq}, 32'h1, "irq raised");
        chk({31'h0, pwm_out[0]}, 32'h0, "stopped output");
        apb(1'b1, 8'h44, 32'h1);
        apb(1'b0, 8'h44, 32'h0); chk(rd, 32'h0, "flag cleared");
        chk({31'h0, group_irq}, 32'h0, "irq cleared");
        apb(1'b1, 8'h40, 32'h0);
        // run enable must fall and rise again for a fresh load
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h0C, 32'h5);
        apb(1'b1, 8'h08, 32'h9);
        tick(20);
        apb(1'b0, 8'h14, 32'h0); chk(rd, 32'h5, "prescale zero");
        tick(20);
        apb(1'b0, 8'h14, 32'h0); chk(rd, 32'h5, "still held");
        apb(1'b1, 8'h08, 32'h0);
    endtask
    task automatic t_dead();
        int both;
        int odd_hi;
        both = 0;
        odd_hi = 0;
        apb(1'b1, 8'h04, 32'h4);
        apb(1'b1, 8'h00, 32'h0001_0001);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h0C, 32'h4);
        apb(1'b1, 8'h7C, 32'h3);
        apb(1'b1, 8'h08, 32'h19);
        tick(40);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            if (pwm_out[0] === 1'b1 && pwm_out[1] === 1'b1) both++;
            if (pwm_out[1] === 1'b1) odd_hi++;
        end
        chk(both, 0, "pair overlap");
        chk({31'h0, odd_hi > 0}, 32'h1, "odd follows even");
        chk({31'h0, high_len > 16'h0 && high_len < 16'h4}, 32'h1,
            "rise delayed");
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h7C, 32'h0);
    endtask
    task automatic t_capture();
        // capture start order, pin output off and capture input on
        apb(1'b1, 8'h7C, 32'h0);
        apb(1'b1, 8'h04, 32'h44);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h50, 32'h000E_0000);
        apb(1'b1, 8'h18, 32'hC8);
        apb(1'b1, 8'h78, 32'h2);
        apb(1'b1, 8'h08, 32'h100);
        tick(40);
        pulse(1);
        tick(3);
        chk({31'h0, group_irq}, 32'h1, "capture irq");
        apb(1'b0, 8'h50, 32'h0); chk(rd, 32'h001E_0000, "rise flag");
        apb(1'b0, 8'h60, 32'h0);
        chk({31'h0, rd > 32'd100 && rd < 32'd200}, 32'h1, "rise latch");
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, rd > 32'd185 && rd <= 32'd200}, 32'h1, "reloaded");
        apb(1'b1, 8'h50, 32'h001E_0000);
        chk({31'h0, group_irq}, 32'h0, "flag cleared");
        tick(30);
        pulse(1);
        tick(3);
        apb(1'b0, 8'h64, 32'h0);
        chk({31'h0, rd > 32'd100 && rd < 32'd200}, 32'h1, "fall latch");
        apb(1'b0, 8'h50, 32'h0); chk(rd, 32'h001E_0000, "fall flag");
        apb(1'b1, 8'h50, 32'h001C_0000);
        pulse(1);
        tick(3);
        apb(1'b0, 8'h50, 32'h0); chk(rd, 32'h000C_0000, "rise gated");
        chk({31'h0, group_irq}, 32'h0, "no irq");
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial begin
        errors = 0;
        checks_done = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        toggle_req = 4'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_pwm();
        t_oneshot();
        t_dead();
        t_capture();
        complete_run();
    end
endmodule
`default_nettype wire
